// ### hw/bridge_pkg.sv
// Package of constants shared by the half-bridge interlock and protection logic.
package bridge_pkg;

   // System clock rate.
   localparam int CLK_MHZ = 25;

   // Overcurrent sample point after the high-side command rises, rounded up to whole cycles.
   localparam int DEBOUNCE_NS = 1500;
   localparam int DEBOUNCE_CYCLES = (DEBOUNCE_NS * CLK_MHZ + 999) / 1000;
   localparam int DBC_W = 6;

   // Consecutive overcurrent hits that start current limiting.
   localparam int OC_HITS = 14;
   localparam int OC_CNT_W = 4;

   // Register byte offsets.
   localparam logic [7:0] STATE_OFF = 8'h00;
   localparam logic [7:0] EVENT_OFF = 8'h04;
   localparam logic [7:0] MASK_OFF = 8'h08;
   localparam logic [7:0] CTRL_OFF = 8'h0c;

   // Event bit positions, shared by the event and mask registers.
   localparam int EV_SHORT = 0;
   localparam int EV_LIMIT = 1;
   localparam int EV_HOT = 2;
   localparam int EV_UNDERVOLTAGE_LOCKOUT = 3;
   localparam int EV_CONFLICT = 4;
   localparam int EV_OC_HIT = 5;
   localparam int EV_W = 6;

   // State register field positions.
   localparam int ST_OWNER = 0;
   localparam int ST_LIMIT = 2;
   localparam int ST_SHORT = 3;
   localparam int ST_HOT = 4;
   localparam int ST_UNDERVOLTAGE_LOCKOUT = 5;
   localparam int ST_HGATE = 6;
   localparam int ST_LGATE = 7;
   localparam int ST_OCCNT = 8;

   // Control register field and reset values.
   localparam int CTRL_REDUCE_EN = 0;
   localparam logic [EV_W-1:0] MASK_RESET = 6'h00;
   localparam logic CTRL_REDUCE_RESET = 1'b1;

   // Which command input currently owns the bridge; one bit changes from idle to either side.
   typedef enum logic [1:0] {
      OWN_NONE = 2'b00,
      OWN_HIGH = 2'b01,
      OWN_LOW = 2'b10
   } owner_t;

endpackage

// ### hw/pin_sync3.sv
// Three-stage pin synchroniser whose output rises only when stages two and three are both high and falls as soon as they differ.
`timescale 1ns/1ns
module pin_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pin,
   output logic [WIDTH-1:0] level
);

   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_next;

   // A bit rises only when two settled stages agree high, so one metastable high sample cannot pass; it falls when they differ.
   assign level_next = (s2_reg & s3_reg) | (level & ~(s2_reg ^ s3_reg));

   // The first stage feeds the second stage and nothing else.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         s1_reg <= '0;
         s2_reg <= '0;
         s3_reg <= '0;
         level <= '0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         level <= level_next;
      end
   end

endmodule // pin_sync3

// ### hw/half_bridge_interlock_protection.sv
// Half-bridge command interlock, overcurrent limiting, fault lockouts and AHB-Lite register slave.
//
// How it works
// - A command rising while the other is high is ignored, never both gates.
// - Simultaneous conflicting commands leave the phase output as it already was.
// - Overcurrent is sampled once per high-side pulse, 1.5 us after it rises.
// - Each sample above the 34 A flag advances the overcurrent hit counter.
// - The fourteenth consecutive hit forces high side off, low side on: current limit.
// - Current limit ends when the current falls below 0.8 of the threshold.
// - Above 68 A a short-circuit latch sets and drives the monitor pin high.
// - Only the supply reset clears the short-circuit latch; the controller cycles supply.
// - Over-temperature sets at 140 C and clears only at 120 C.
// - Bootstrap undervoltage lockout follows the input supply below 5.8 V flag.
// - A floating or above 4 V strength input selects full drive.
// - Reduced drive only in the Miller plateau with gate voltage above 1 V.
`timescale 1ns/1ns
module half_bridge_interlock_protection
   import bridge_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic high_side_pwm_in,
   input wire logic low_side_pwm_in,
   input wire logic oc_above_flag,
   input wire logic oc_release_flag,
   input wire logic short_above_flag,
   input wire logic temp_hot_flag,
   input wire logic temp_cool_flag,
   input wire logic undervoltage_flag,
   input wire logic source_strength_set_max,
   input wire logic sink_strength_set_max,
   input wire logic miller_plateau_flag,
   input wire logic gate_above_1v_flag,
   input wire logic hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   output logic high_gate_on,
   output logic low_gate_on,
   output logic phase_output,
   output logic temp_fault_monitor_out,
   output logic source_drive_reduced,
   output logic sink_drive_reduced,
   output logic irq
);

   localparam logic [DBC_W-1:0] DBC_LAST = DBC_W'(DEBOUNCE_CYCLES - 1);
   localparam logic [OC_CNT_W-1:0] OC_LAST = OC_CNT_W'(OC_HITS - 1);

   // Word decode of the low address byte, used by both the read and write paths.
   function automatic logic word_hit(input logic [7:0] addr, input logic [7:0] off);
      word_hit = (addr[7:2] == off[7:2]);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Pin inputs.
   localparam int NPIN = 12;
   logic [NPIN-1:0] pin_level;
   logic hs_cmd;
   logic ls_cmd;
   logic oc_above;
   logic oc_release;
   logic short_above;
   logic temp_hot;
   logic temp_cool;
   logic uv_low;
   logic src_max;
   logic snk_max;
   logic miller;
   logic gate_1v;

   // Every comparator and command pin is asynchronous to the clock.
   pin_sync3 #(.WIDTH(NPIN)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .pin({gate_above_1v_flag, miller_plateau_flag, sink_strength_set_max, source_strength_set_max,
            undervoltage_flag, temp_cool_flag, temp_hot_flag, short_above_flag,
            oc_release_flag, oc_above_flag, low_side_pwm_in, high_side_pwm_in}),
      .level(pin_level)
   );

   assign {gate_1v, miller, snk_max, src_max, uv_low, temp_cool, temp_hot, short_above,
           oc_release, oc_above, ls_cmd, hs_cmd} = pin_level;

   ////////////////////////////////////////////////////////////////////////////////
   // Command interlock.
   owner_t owner_reg;
   owner_t owner_next;
   logic hs_prev_reg;
   logic ls_prev_reg;
   logic hs_rise;
   logic ls_rise;
   logic conflict;

   assign hs_rise = hs_cmd & ~hs_prev_reg;
   assign ls_rise = ls_cmd & ~ls_prev_reg;
   // Both commands seen rising in the same cycle from idle.
   assign conflict = hs_rise & ls_rise;

   // Ownership goes to whichever command rose first and is held until that command falls.
   always_comb begin
      owner_next = owner_reg;
      case (owner_reg)
         OWN_NONE: begin
            if (hs_rise && !ls_cmd) begin
               owner_next = OWN_HIGH;
            end else if (ls_rise && !hs_cmd) begin
               owner_next = OWN_LOW;
            end else begin
               owner_next = OWN_NONE;
            end
         end
         OWN_HIGH: owner_next = hs_cmd ? OWN_HIGH : OWN_NONE;
         OWN_LOW: owner_next = ls_cmd ? OWN_LOW : OWN_NONE;
         default: begin
            owner_next = OWN_NONE;
         end
      endcase
   end

   // A command that lost the race must fall and rise again; this avoids handing the bridge
   // straight across while the losing input may still be carrying a stale pulse.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         owner_reg <= OWN_NONE;
         hs_prev_reg <= 1'b0;
         ls_prev_reg <= 1'b0;
      end else begin
         owner_reg <= owner_next;
         hs_prev_reg <= hs_cmd;
         ls_prev_reg <= ls_cmd;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overcurrent sampling and current limit.
   logic dbc_run_reg;
   logic dbc_run_next;
   logic [DBC_W-1:0] dbc_cnt_reg;
   logic [DBC_W-1:0] dbc_cnt_next;
   logic sample_now;
   logic oc_hit;
   logic limit_enter;
   logic [OC_CNT_W-1:0] oc_cnt_reg;
   logic [OC_CNT_W-1:0] oc_cnt_next;
   logic limit_reg;
   logic limit_next;

   // The debounce timer starts on each high-side rise and is dropped if the pulse ends early.
   assign sample_now = dbc_run_reg & hs_cmd & (dbc_cnt_reg == DBC_LAST);
   assign oc_hit = sample_now & oc_above;
   assign limit_enter = oc_hit & (oc_cnt_reg == OC_LAST);
   assign dbc_run_next = hs_rise | (dbc_run_reg & hs_cmd & ~sample_now);
   assign dbc_cnt_next = hs_rise ? '0 : (dbc_cnt_reg + 1'b1);

   // Hit counter: advance on a hit, clear on a clean sample or on entering the limit.
   assign oc_cnt_next = limit_enter ? '0 :
                        oc_hit ? (oc_cnt_reg + 1'b1) :
                        sample_now ? '0 :
                        oc_cnt_reg;

   // Entry takes priority over release so a fresh hit is never lost.
   assign limit_next = limit_enter | (limit_reg & ~oc_release);

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         dbc_run_reg <= 1'b0;
         dbc_cnt_reg <= '0;
         oc_cnt_reg <= '0;
         limit_reg <= 1'b0;
      end else begin
         dbc_run_reg <= dbc_run_next;
         dbc_cnt_reg <= dbc_cnt_next;
         oc_cnt_reg <= oc_cnt_next;
         limit_reg <= limit_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Fault lockouts.
   logic short_reg;
   logic hot_reg;
   logic uv_reg;
   logic lockout;

   // The short-circuit latch has no clear path other than the supply reset.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         short_reg <= 1'b0;
         hot_reg <= 1'b0;
         uv_reg <= 1'b0;
      end else begin
         short_reg <= short_reg | short_above;
         hot_reg <= temp_hot | (hot_reg & ~temp_cool);
         uv_reg <= uv_low;
      end
   end

   assign lockout = short_reg | hot_reg | uv_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Gate and drive-strength outputs.
   logic ctrl_reduce_reg;
   logic hgate_next;
   logic lgate_next;
   logic reduce_window;

   // Current limit overrides the command owner; lockout overrides everything.
   assign hgate_next = ~lockout & ~limit_reg & (owner_next == OWN_HIGH);
   assign lgate_next = ~lockout & (limit_reg | (owner_next == OWN_LOW));
   assign reduce_window = ctrl_reduce_reg & miller & gate_1v;

   // Phase output holds its last level when no side conducts, so a conflict leaves it alone.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         high_gate_on <= 1'b0;
         low_gate_on <= 1'b0;
         phase_output <= 1'b0;
         temp_fault_monitor_out <= 1'b0;
         source_drive_reduced <= 1'b0;
         sink_drive_reduced <= 1'b0;
      end else begin
         high_gate_on <= hgate_next;
         low_gate_on <= lgate_next;
         phase_output <= hgate_next | (phase_output & ~lgate_next);
         temp_fault_monitor_out <= short_reg;
         source_drive_reduced <= reduce_window & ~src_max;
         sink_drive_reduced <= reduce_window & ~snk_max;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Events and interrupt.
   logic short_prev_reg;
   logic limit_prev_reg;
   logic hot_prev_reg;
   logic uv_prev_reg;
   logic [EV_W-1:0] ev_set;
   logic [EV_W-1:0] ev_clr;
   logic [EV_W-1:0] event_reg;
   logic [EV_W-1:0] mask_reg;

   assign ev_set[EV_SHORT] = short_reg & ~short_prev_reg;
   assign ev_set[EV_LIMIT] = limit_reg & ~limit_prev_reg;
   assign ev_set[EV_HOT] = hot_reg & ~hot_prev_reg;
   assign ev_set[EV_UNDERVOLTAGE_LOCKOUT] = uv_reg & ~uv_prev_reg;
   assign ev_set[EV_CONFLICT] = conflict;
   assign ev_set[EV_OC_HIT] = oc_hit;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         short_prev_reg <= 1'b0;
         limit_prev_reg <= 1'b0;
         hot_prev_reg <= 1'b0;
         uv_prev_reg <= 1'b0;
         event_reg <= '0;
         irq <= 1'b0;
      end else begin
         short_prev_reg <= short_reg;
         limit_prev_reg <= limit_reg;
         hot_prev_reg <= hot_reg;
         uv_prev_reg <= uv_reg;
         // A set arriving with the clearing write wins.
         event_reg <= (event_reg & ~ev_clr) | ev_set;
         irq <= |(event_reg & mask_reg);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states, always OKAY.
   logic addr_take;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;
   logic wr_event;
   logic wr_mask;
   logic wr_ctrl;
   logic [31:0] state_word;
   logic [31:0] rd_word;
   logic [7:0] rd_addr;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Only word transfers are mapped; narrower sizes are accepted and treated as words.
   assign addr_take = hsel & htrans[1] & hready;
   assign rd_addr = haddr[7:0];

   assign wr_event = wr_pend_reg & word_hit(wr_addr_reg, EVENT_OFF);
   assign wr_mask = wr_pend_reg & word_hit(wr_addr_reg, MASK_OFF);
   assign wr_ctrl = wr_pend_reg & word_hit(wr_addr_reg, CTRL_OFF);
   assign ev_clr = wr_event ? hwdata[EV_W-1:0] : '0;

   assign state_word = {{(32 - ST_OCCNT - OC_CNT_W){1'b0}}, oc_cnt_reg, low_gate_on, high_gate_on,
                        uv_reg, hot_reg, short_reg, limit_reg, owner_reg};

   // Read data is chosen in the address phase and registered for the data phase.
   assign rd_word = word_hit(rd_addr, STATE_OFF) ? state_word :
                    word_hit(rd_addr, EVENT_OFF) ? {{(32 - EV_W){1'b0}}, event_reg} :
                    word_hit(rd_addr, MASK_OFF) ? {{(32 - EV_W){1'b0}}, mask_reg} :
                    word_hit(rd_addr, CTRL_OFF) ? {31'h0, ctrl_reduce_reg} :
                    32'h0000_0000;

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata <= 32'h0000_0000;
      end else begin
         wr_pend_reg <= addr_take & hwrite;
         wr_addr_reg <= addr_take ? haddr[7:0] : wr_addr_reg;
         hrdata <= (addr_take && !hwrite) ? rd_word : hrdata;
      end
   end

   // Software mask and drive control.
   always_ff @(posedge clk_sys) begin
      if (rst) begin
         mask_reg <= MASK_RESET;
         ctrl_reduce_reg <= CTRL_REDUCE_RESET;
      end else begin
         mask_reg <= wr_mask ? hwdata[EV_W-1:0] : mask_reg;
         ctrl_reduce_reg <= wr_ctrl ? hwdata[CTRL_REDUCE_EN] : ctrl_reduce_reg;
      end
   end

endmodule // half_bridge_interlock_protection

// ### tb/hbip_asserts.sv
// Checker of the gate, fault and drive outputs of the half-bridge block.
`timescale 1ns/1ns
module hbip_asserts (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic short_above_flag,
   input wire logic undervoltage_flag,
   input wire logic sink_strength_set_max,
   input wire logic miller_plateau_flag,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic high_gate_on,
   input wire logic low_gate_on,
   input wire logic phase_output,
   input wire logic temp_fault_monitor_out,
   input wire logic source_drive_reduced,
   input wire logic sink_drive_reduced
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // Six samples cover the three-flop synchroniser, its level flop, the fault register and the output register.
   sequence s_short_held; short_above_flag [*6]; endsequence
   sequence s_uv_held; undervoltage_flag [*6]; endsequence
   property p_no_overlap; !(high_gate_on && low_gate_on); endproperty
   property p_phase_high; $rose(high_gate_on) |-> ##[0:1] phase_output; endproperty
   property p_phase_low; $rose(low_gate_on) |-> ##[0:1] !phase_output; endproperty
   property p_short_sets; s_short_held |-> ##[0:2] temp_fault_monitor_out; endproperty
   property p_short_holds; temp_fault_monitor_out |=> temp_fault_monitor_out; endproperty
   property p_short_off; temp_fault_monitor_out |=> !high_gate_on && !low_gate_on; endproperty
   property p_uv_off; s_uv_held |=> !high_gate_on && !low_gate_on; endproperty
   property p_sink_max; sink_strength_set_max [*6] |-> !sink_drive_reduced; endproperty
   property p_no_miller; !miller_plateau_flag [*6] |-> !source_drive_reduced && !sink_drive_reduced; endproperty
   property p_okay; hreadyout && !hresp; endproperty
   a_no_overlap: assert property (p_no_overlap) else $error("both gates on");
   a_phase_high: assert property (p_phase_high) else $error("phase not high");
   a_phase_low: assert property (p_phase_low) else $error("phase not low");
   a_short_sets: assert property (p_short_sets) else $error("short not latched");
   a_short_holds: assert property (p_short_holds) else $error("short latch lost");
   a_short_off: assert property (p_short_off) else $error("gate on in short");
   a_uv_off: assert property (p_uv_off) else $error("gate on in lockout");
   a_sink_max: assert property (p_sink_max) else $error("sink reduced at max");
   a_no_miller: assert property (p_no_miller) else $error("reduced off plateau");
   a_okay: assert property (p_okay) else $error("bus not ready or error");
endmodule // hbip_asserts

bind half_bridge_interlock_protection hbip_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
   .short_above_flag(short_above_flag), .undervoltage_flag(undervoltage_flag),
   .sink_strength_set_max(sink_strength_set_max), .miller_plateau_flag(miller_plateau_flag),
   .hreadyout(hreadyout), .hresp(hresp), .high_gate_on(high_gate_on), .low_gate_on(low_gate_on),
   .phase_output(phase_output), .temp_fault_monitor_out(temp_fault_monitor_out),
   .source_drive_reduced(source_drive_reduced), .sink_drive_reduced(sink_drive_reduced));

// ### tb/pwm_ctrl_model.sv
// Model of the motor controller that drives the two command pins.
`timescale 1ns/1ns
module pwm_ctrl_model (
   input wire logic clk_sys,
   output logic high_side_pwm_in,
   output logic low_side_pwm_in
);
   // Separate pins for each switch; both change on one edge so a clash is exact.
   initial begin
      high_side_pwm_in = 1'b0;
      low_side_pwm_in = 1'b0;
   end

   // Drives both commands just after a rising edge.
   task automatic set_cmd(input logic h, input logic l);
      @(posedge clk_sys);
      high_side_pwm_in <= h;
      low_side_pwm_in <= l;
   endtask
endmodule // pwm_ctrl_model

// ### tb/half_bridge_interlock_protection_tb.sv
// Self-checking bench of the half-bridge interlock and protection block.
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module half_bridge_interlock_protection_tb;
   import bridge_pkg::*;
   logic clk_sys = 1'b0, rst = 1'b1, hs, ls, oc = 1'b0, rel = 1'b0, sc = 1'b0, hot = 1'b0, cool = 1'b0;
   logic uv = 1'b0, src_max = 1'b0, snk_max = 1'b1, mil = 1'b0, g1v = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic hready, hreadyout, hresp;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'b00;
   logic [2:0] hsize = 3'b000;
   logic hg, lg, ph, mon, srd, skd, irq;
   int errors = 0, cmp_count = 0;
   assign hready = hreadyout;
   initial forever #20 clk_sys = ~clk_sys;
   pwm_ctrl_model m (.clk_sys(clk_sys), .high_side_pwm_in(hs), .low_side_pwm_in(ls));
   half_bridge_interlock_protection DUT (.clk_sys(clk_sys), .rst(rst), .high_side_pwm_in(hs),
      .low_side_pwm_in(ls), .oc_above_flag(oc), .oc_release_flag(rel), .short_above_flag(sc),
      .temp_hot_flag(hot), .temp_cool_flag(cool), .undervoltage_flag(uv), .source_strength_set_max(src_max),
      .sink_strength_set_max(snk_max), .miller_plateau_flag(mil), .gate_above_1v_flag(g1v), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .high_gate_on(hg), .low_gate_on(lg),
      .phase_output(ph), .temp_fault_monitor_out(mon), .source_drive_reduced(srd),
      .sink_drive_reduced(skd), .irq(irq));
   ////////////////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   // Single word transfer; the master waits on hready in both phases.
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
      @(posedge clk_sys);
      hsel <= 1; htrans <= 2'b10; haddr <= {24'h0, a}; hwrite <= w; hsize <= 3'b010;
      do @(posedge clk_sys); while (hready !== 1'b1);
      hsel <= 0; htrans <= 2'b00; hwdata <= wd;
      do @(posedge clk_sys); while (hready !== 1'b1);
      rd = hrdata;
   endtask
   // Gates come up five edges after a pin, so six cycles is settled.
   task automatic t_reset;
      `CHK("gates", 2'b00, {hg, lg})
      ahb(0, STATE_OFF, 0); `CHK("state", 32'h0, rd)
      ahb(0, MASK_OFF, 0); `CHK("mask", 32'h0, rd)
      ahb(0, CTRL_OFF, 0); `CHK("ctrl", 32'h1, rd)
      ahb(1, 8'h10, 32'hffffffff); ahb(0, 8'h10, 0); `CHK("unmapped", 32'h0, rd)
   endtask
   task automatic t_interlock;
      m.set_cmd(1, 0); cyc(6); `CHK("phase hi", 1'b1, ph)
      m.set_cmd(1, 1); cyc(6); `CHK("late low", 2'b10, {hg, lg})
      m.set_cmd(0, 1); cyc(6); `CHK("low held off", 1'b0, lg)
      m.set_cmd(0, 0); cyc(6);
      m.set_cmd(1, 1); cyc(6); `CHK("clash gates", 2'b00, {hg, lg})
      `CHK("clash phase", 1'b1, ph)
      ahb(0, EVENT_OFF, 0); `CHK("clash event", 1'b1, rd[EV_CONFLICT])
      m.set_cmd(0, 0); cyc(6);
   endtask
   // Pulses of 50 cycles pass the 38-cycle sample point plus synchroniser delay.
   task automatic pulses(input int n);
      repeat (n) begin
         m.set_cmd(1, 0); cyc(50); m.set_cmd(0, 0); cyc(10);
      end
   endtask
   task automatic t_overcurrent;
      oc <= 1; pulses(13);
      ahb(0, STATE_OFF, 0); `CHK("hits", 4'hd, rd[11:8])
      oc <= 0; pulses(1);
      ahb(0, STATE_OFF, 0); `CHK("hits cleared", 4'h0, rd[11:8])
      oc <= 1; pulses(13);
      m.set_cmd(1, 0); cyc(42); `CHK("before sample", 2'b10, {hg, lg})
      cyc(6); `CHK("limit gates", 2'b01, {hg, lg})
      ahb(0, STATE_OFF, 0); `CHK("limit bit", 1'b1, rd[ST_LIMIT])
      oc <= 0; cyc(10); `CHK("limit kept", 2'b01, {hg, lg})
      rel <= 1; cyc(8); rel <= 0; `CHK("limit left", 2'b10, {hg, lg})
   endtask
   // Fault flags pass one register more than the commands, so eight cycles are allowed.
   task automatic t_lockouts;
      uv <= 1; cyc(8); `CHK("uv gates", 2'b00, {hg, lg})
      `CHK("masked irq", 1'b0, irq)
      ahb(0, EVENT_OFF, 0); `CHK("uv event", 1'b1, rd[EV_UNDERVOLTAGE_LOCKOUT])
      uv <= 0; cyc(8); `CHK("uv gone", 1'b1, hg)
      hot <= 1; cyc(6); hot <= 0; cyc(6); `CHK("hot held", 2'b00, {hg, lg})
      cool <= 1; cyc(8); cool <= 0; `CHK("cooled", 1'b1, hg)
   endtask
   task automatic t_drive;
      mil <= 1; g1v <= 1; cyc(6); `CHK("reduced", 2'b10, {srd, skd})
      g1v <= 0; cyc(6); `CHK("below 1 V", 1'b0, srd)
      g1v <= 1; ahb(1, CTRL_OFF, 0); cyc(6); `CHK("ctrl off", 1'b0, srd)
      mil <= 0; ahb(1, CTRL_OFF, 1);
   endtask
   task automatic t_short;
      ahb(1, EVENT_OFF, 32'h3f); ahb(1, MASK_OFF, 32'h1 << EV_SHORT);
      sc <= 1; cyc(8); sc <= 0; `CHK("monitor", 1'b1, mon)
      `CHK("short gates", 2'b00, {hg, lg})
      `CHK("irq set", 1'b1, irq)
      ahb(1, EVENT_OFF, 32'h1 << EV_SHORT); cyc(3); `CHK("irq clear", 1'b0, irq)
      cyc(20); `CHK("latched", 1'b1, mon)
      rst <= 1; cyc(5); rst <= 0; cyc(6); `CHK("reset clears", 1'b0, mon)
      ahb(0, MASK_OFF, 0); `CHK("mask reset", 32'h0, rd)
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Tests take about 2000 cycles; the watchdog allows far more.
   initial begin
      cyc(20000);
      errors++;
      tally_and_finish();
   end
   initial begin
      cyc(5); rst <= 0; cyc(1);
      t_reset(); t_interlock(); t_overcurrent(); t_lockouts(); t_drive(); t_short();
      tally_and_finish();
   end
endmodule // half_bridge_interlock_protection_tb
